/* File: include/aics_pkg.sv */
// Purpose: constants for the add-on interrupt control and status block
// Assumes: one 32-bit register at a fixed add-on offset
// Notes: flag order below follows the bit order 16 upward
`default_nettype none

package aics_pkg;
  // register placement and reset value
  localparam logic [7:0] AICS_OFS_IRQ = 8'h38;
  localparam logic [31:0] AICS_IRQ_RESET = 32'h0000_0000;
  // field layout
  localparam logic [31:0] AICS_RW_MASK = 32'h0000_DF1F;
  localparam logic [31:0] AICS_FLAG_MASK = 32'h003F_0000;
  localparam logic [31:0] AICS_RSVD_MASK = 32'hFF40_20E0;
  localparam int AICS_BIT_SUMMARY = 23;
  localparam int AICS_FLAG_LSB = 16;
  localparam int AICS_FLAG_MSB = 21;
  localparam int AICS_BIT_EN_RD = 15;
  localparam int AICS_BIT_EN_WR = 14;
  localparam int AICS_BIT_EN_OMB = 12;
  localparam int AICS_OMB_SEL_LSB = 10;
  localparam int AICS_OMB_BYTE_LSB = 8;
  localparam int AICS_BIT_EN_IMB = 4;
  localparam int AICS_IMB_SEL_LSB = 2;
  localparam int AICS_IMB_BYTE_LSB = 0;
  // index of each latched flag inside the flag vector
  localparam int AICS_NUM_FLAGS = 6;
  localparam int AICS_FLG_IMB = 0;
  localparam int AICS_FLG_OMB = 1;
  localparam int AICS_FLG_WDONE = 2;
  localparam int AICS_FLG_RDONE = 3;
  localparam int AICS_FLG_BIST = 4;
  localparam int AICS_FLG_ABORT = 5;
  // mailbox geometry: four mailboxes of four bytes
  localparam int AICS_MBOX_BYTES = 16;

  typedef logic [AICS_NUM_FLAGS-1:0] aics_flags_type;
endpackage : aics_pkg

`default_nettype wire

/* File: logic/aics_mbox_pick.sv */
// Purpose: picks one mailbox byte strobe out of sixteen
// Assumes: strobe bit 4*mailbox+byte, mailbox and byte zero based
// Notes: purely combinational, no state
`timescale 1ns/1ns
`default_nettype none

module aics_mbox_pick
  import aics_pkg::*;
(
  input wire logic [AICS_MBOX_BYTES-1:0] strobe,
  input wire logic [1:0] mbox_sel,
  input wire logic [1:0] byte_sel,
  output logic hit
);

  function automatic logic [3:0] byte_index(input logic [1:0] mb, input logic [1:0] bt);
    byte_index = {mb, bt};
  endfunction : byte_index

  always_comb begin
    hit = strobe[byte_index(mbox_sel, byte_sel)];
  end

endmodule : aics_mbox_pick

`default_nettype wire

/* File: logic/aics_sticky.sv */
// Purpose: bank of latched event flags with one-to-clear
// Assumes: set and clear are one-cycle pulses on clk
// Notes: a set in the clearing cycle wins so no event is lost
`timescale 1ns/1ns
`default_nettype none

module aics_sticky
  import aics_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire aics_flags_type set,
  input wire aics_flags_type clr,
  output aics_flags_type flags
);

  typedef struct packed {
    aics_flags_type flags;
  } aics_sticky_state_type;

  aics_sticky_state_type state_ff;
  aics_sticky_state_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.flags = (state_ff.flags & ~clr) | set; // R3
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= AICS_IRQ_RESET[AICS_FLAG_MSB:AICS_FLAG_LSB];
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flags = state_ff.flags;

  set_wins_a: assert property (@(posedge clk) disable iff (rst) // R3
    (|set) |=> ((flags & $past(set)) == $past(set)))
    else $error("a flag set in a clearing cycle was lost");

endmodule : aics_sticky

`default_nettype wire

/* File: logic/aics_top.sv */
// Purpose: add-on side interrupt control and status register
// Assumes: event inputs are one-cycle pulses from logic on clk
// Notes: the register answers only at its own word offset
// Notes on behaviour
// R1: bit 23 reads OR of latched flags
// R2: bit 21 latches on master or target abort
// R3: writing one clears a flag, zero keeps
// R4: bit 20 sets on self-test start, stays set until a write of one clears it
// R5: bit 19 sets when read count hits zero
// R6: bit 18 sets when write count hits zero
// R7: bit 17 sets on selected outgoing byte read
// R8: bit 16 sets on selected incoming byte write
// R9: bit 15 enables read-count-zero interrupt
// R10: bit 14 enables write-count-zero interrupt
// R11: bit 12 enables outgoing mailbox interrupt
// R12: bits 11:10 choose outgoing mailbox one to four
// R13: bits 9:8 choose outgoing mailbox byte
// R14: bit 4 enables incoming mailbox interrupt
// R15: bits 3:2 choose incoming mailbox one to four
// R16: bits 1:0 choose incoming mailbox byte
// R17: reserved bits always read zero
// R18: incoming from host, outgoing toward host
// R19: interrupt pin active while bit 23 set
`timescale 1ns/1ns
`default_nettype none

module aics_top
  import aics_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic addon_sel,
  input wire logic [5:2] addon_addr,
  input wire logic [3:0] addon_be,
  input wire logic addon_wr,
  input wire logic addon_rd,
  input wire logic [31:0] addon_wdata,
  output logic [31:0] addon_rdata,
  input wire logic [AICS_MBOX_BYTES-1:0] pci_imb_wr_byte,
  input wire logic [AICS_MBOX_BYTES-1:0] pci_omb_rd_byte,
  input wire logic pci_bist_start,
  input wire logic mst_rd_count_zero,
  input wire logic mst_wr_count_zero,
  input wire logic pci_master_abort,
  input wire logic pci_target_abort,
  output logic addon_irq_n
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
  } aics_top_state_type;

  aics_top_state_type state_ff;
  aics_top_state_type nxt_state;

  aics_flags_type flags;
  aics_flags_type flag_set;
  aics_flags_type flag_clr;
  logic imb_hit;
  logic omb_hit;
  logic wr_hit;
  logic rd_any;
  logic rd_hit;
  logic summary;
  logic [31:0] lanes;
  logic [31:0] reg_value;

  // byte enables widen to a bit mask; narrow add-on writes touch only their lanes
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] place_flags(input aics_flags_type f, input logic s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[AICS_FLAG_MSB:AICS_FLAG_LSB] = f;
    v[AICS_BIT_SUMMARY] = s;
    place_flags = v;
  endfunction : place_flags

  // ---- bus decode
  assign wr_hit = addon_sel && addon_wr && (addon_addr == AICS_OFS_IRQ[5:2]);
  assign rd_any = addon_sel && addon_rd;
  assign rd_hit = rd_any && (addon_addr == AICS_OFS_IRQ[5:2]);
  assign lanes = lane_mask(addon_be);

  // ---- mailbox byte selection
  // incoming bytes are written by the host and read here; outgoing the reverse
  aics_mbox_pick u_imb_pick (
    .strobe(pci_imb_wr_byte), // R18
    .mbox_sel(state_ff.ctrl[AICS_IMB_SEL_LSB+1:AICS_IMB_SEL_LSB]), // R15
    .byte_sel(state_ff.ctrl[AICS_IMB_BYTE_LSB+1:AICS_IMB_BYTE_LSB]), // R16
    .hit(imb_hit)
  );

  aics_mbox_pick u_omb_pick (
    .strobe(pci_omb_rd_byte), // R18
    .mbox_sel(state_ff.ctrl[AICS_OMB_SEL_LSB+1:AICS_OMB_SEL_LSB]), // R12
    .byte_sel(state_ff.ctrl[AICS_OMB_BYTE_LSB+1:AICS_OMB_BYTE_LSB]), // R13
    .hit(omb_hit)
  );

  // ---- event sources
  // enables gate the latch itself, so a masked source never shows as a flag
  always_comb begin
    flag_set = '0;
    flag_set[AICS_FLG_IMB] = imb_hit && state_ff.ctrl[AICS_BIT_EN_IMB]; // R8 R14
    flag_set[AICS_FLG_OMB] = omb_hit && state_ff.ctrl[AICS_BIT_EN_OMB]; // R7 R11
    flag_set[AICS_FLG_WDONE] = mst_wr_count_zero && state_ff.ctrl[AICS_BIT_EN_WR]; // R6 R10
    flag_set[AICS_FLG_RDONE] = mst_rd_count_zero && state_ff.ctrl[AICS_BIT_EN_RD]; // R5 R9
    flag_set[AICS_FLG_BIST] = pci_bist_start; // R4
    flag_set[AICS_FLG_ABORT] = pci_master_abort || pci_target_abort; // R2
  end

  always_comb begin
    flag_clr = '0;
    if (wr_hit) begin
      flag_clr = addon_wdata[AICS_FLAG_MSB:AICS_FLAG_LSB] & lanes[AICS_FLAG_MSB:AICS_FLAG_LSB]; // R3
    end
  end

  aics_sticky u_flags (
    .clk(clk),
    .rst(rst),
    .set(flag_set),
    .clr(flag_clr),
    .flags(flags)
  );

  // ---- register image
  assign summary = |flags; // R1
  assign reg_value = (state_ff.ctrl & AICS_RW_MASK) | place_flags(flags, summary); // R17

  // ---- state update
  always_comb begin
    nxt_state = state_ff;
    if (wr_hit) begin
      nxt_state.ctrl = (state_ff.ctrl & ~(lanes & AICS_RW_MASK)) |
                       (addon_wdata & lanes & AICS_RW_MASK); // R9 R10 R11 R12 R13 R14 R15 R16
    end
    if (rd_any) begin
      // an unmapped read returns zero rather than stale data
      nxt_state.rdata = rd_hit ? reg_value : 32'h0000_0000; // R17
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff.ctrl <= AICS_IRQ_RESET;
      state_ff.rdata <= AICS_IRQ_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign addon_rdata = state_ff.rdata;
  // a level made from flag flip-flops; it drops the cycle after the last clear
  assign addon_irq_n = ~summary; // R19

  // ---- checks
  summary_or_a: assert property (@(posedge clk) disable iff (rst) // R1
    reg_value[AICS_BIT_SUMMARY] == (reg_value[AICS_FLAG_MSB:AICS_FLAG_LSB] != '0))
    else $error("summary bit differs from OR of flags");

  summary_read_a: assert property (@(posedge clk) disable iff (rst) // R1
    rd_hit && (flags != '0) |=> addon_rdata[AICS_BIT_SUMMARY])
    else $error("summary bit read zero with a flag set");

  abort_set_a: assert property (@(posedge clk) disable iff (rst) // R2
    (pci_master_abort || pci_target_abort) |=> flags[AICS_FLG_ABORT])
    else $error("abort did not latch");

  abort_hold_a: assert property (@(posedge clk) disable iff (rst) // R2
    flags[AICS_FLG_ABORT] && !wr_hit |=> flags[AICS_FLG_ABORT])
    else $error("abort flag dropped without a write");

  one_clear_a: assert property (@(posedge clk) disable iff (rst) // R3
    wr_hit && addon_be[2] && addon_wdata[AICS_FLG_ABORT+AICS_FLAG_LSB] &&
    !flag_set[AICS_FLG_ABORT] |=> !flags[AICS_FLG_ABORT])
    else $error("write of one did not clear the abort flag");

  zero_keep_a: assert property (@(posedge clk) disable iff (rst) // R3
    wr_hit && flags[AICS_FLG_IMB] && !addon_wdata[AICS_FLAG_LSB] |=> flags[AICS_FLG_IMB])
    else $error("write of zero changed a flag");

  lane_keep_a: assert property (@(posedge clk) disable iff (rst) // R3
    wr_hit && !addon_be[2] && (flags != '0) |=> (flags != '0))
    else $error("write without its byte lane cleared flags");

  bist_set_a: assert property (@(posedge clk) disable iff (rst) // R4
    pci_bist_start |=> flags[AICS_FLG_BIST])
    else $error("self-test flag did not set");

  bist_hold_a: assert property (@(posedge clk) disable iff (rst) // R4
    flags[AICS_FLG_BIST] && !flag_clr[AICS_FLG_BIST] |=> flags[AICS_FLG_BIST])
    else $error("self-test flag dropped without its clear");

  rdone_set_a: assert property (@(posedge clk) disable iff (rst) // R5
    mst_rd_count_zero && state_ff.ctrl[AICS_BIT_EN_RD] |=> flags[AICS_FLG_RDONE])
    else $error("read count zero did not latch");

  wdone_set_a: assert property (@(posedge clk) disable iff (rst) // R6
    mst_wr_count_zero && state_ff.ctrl[AICS_BIT_EN_WR] |=> flags[AICS_FLG_WDONE])
    else $error("write count zero did not latch");

  omb_set_a: assert property (@(posedge clk) disable iff (rst) // R7
    state_ff.ctrl[AICS_BIT_EN_OMB] &&
    pci_omb_rd_byte[state_ff.ctrl[AICS_OMB_SEL_LSB+1:AICS_OMB_BYTE_LSB]]
    |=> flags[AICS_FLG_OMB])
    else $error("selected outgoing byte read did not latch");

  imb_set_a: assert property (@(posedge clk) disable iff (rst) // R8
    state_ff.ctrl[AICS_BIT_EN_IMB] &&
    pci_imb_wr_byte[state_ff.ctrl[AICS_IMB_SEL_LSB+1:AICS_IMB_BYTE_LSB]]
    |=> flags[AICS_FLG_IMB])
    else $error("selected incoming byte write did not latch");

  rd_gate_a: assert property (@(posedge clk) disable iff (rst) // R9
    !state_ff.ctrl[AICS_BIT_EN_RD] && !flags[AICS_FLG_RDONE] |=> !flags[AICS_FLG_RDONE])
    else $error("masked read count zero latched");

  wr_gate_a: assert property (@(posedge clk) disable iff (rst) // R10
    !state_ff.ctrl[AICS_BIT_EN_WR] && !flags[AICS_FLG_WDONE] |=> !flags[AICS_FLG_WDONE])
    else $error("masked write count zero latched");

  omb_gate_a: assert property (@(posedge clk) disable iff (rst) // R11
    !state_ff.ctrl[AICS_BIT_EN_OMB] && !flags[AICS_FLG_OMB] |=> !flags[AICS_FLG_OMB])
    else $error("masked outgoing mailbox event latched");

  ctrl_write_a: assert property (@(posedge clk) disable iff (rst) // R12
    wr_hit && (addon_be == 4'hF) |=> state_ff.ctrl == ($past(addon_wdata) & AICS_RW_MASK))
    else $error("control fields did not take the written value");

  imb_gate_a: assert property (@(posedge clk) disable iff (rst) // R14
    !state_ff.ctrl[AICS_BIT_EN_IMB] && !flags[AICS_FLG_IMB] |=> !flags[AICS_FLG_IMB])
    else $error("masked incoming mailbox event latched");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // R17
    (addon_rdata & AICS_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved bit read as one");

  readback_a: assert property (@(posedge clk) disable iff (rst) // R17
    rd_hit |=> addon_rdata == $past(reg_value))
    else $error("read data differs from register image");

  irq_level_a: assert property (@(posedge clk) disable iff (rst) // R19
    addon_irq_n == !(flags != '0))
    else $error("interrupt pin disagrees with summary");

  irq_drop_a: assert property (@(posedge clk) disable iff (rst) // R19
    wr_hit && ((addon_wdata & lanes & AICS_FLAG_MASK) == AICS_FLAG_MASK) &&
    (flag_set == '0) |=> addon_irq_n)
    else $error("interrupt stayed active after all flags cleared");

  // a flag may only drop through its own one-to-clear
  rdone_hold_a: assert property (@(posedge clk) disable iff (rst) // R5
    flags[AICS_FLG_RDONE] && !flag_clr[AICS_FLG_RDONE] |=> flags[AICS_FLG_RDONE])
    else $error("read count flag dropped without its clear");

  wdone_hold_a: assert property (@(posedge clk) disable iff (rst) // R6
    flags[AICS_FLG_WDONE] && !flag_clr[AICS_FLG_WDONE] |=> flags[AICS_FLG_WDONE])
    else $error("write count flag dropped without its clear");

  omb_hold_a: assert property (@(posedge clk) disable iff (rst) // R7
    flags[AICS_FLG_OMB] && !flag_clr[AICS_FLG_OMB] |=> flags[AICS_FLG_OMB])
    else $error("outgoing mailbox flag dropped without its clear");

  imb_hold_a: assert property (@(posedge clk) disable iff (rst) // R8
    flags[AICS_FLG_IMB] && !flag_clr[AICS_FLG_IMB] |=> flags[AICS_FLG_IMB])
    else $error("incoming mailbox flag dropped without its clear");

  // a flag may only rise through its own event
  abort_free_a: assert property (@(posedge clk) disable iff (rst) // R2
    !flags[AICS_FLG_ABORT] && !pci_master_abort && !pci_target_abort
    |=> !flags[AICS_FLG_ABORT])
    else $error("abort flag set without an abort");

  bist_free_a: assert property (@(posedge clk) disable iff (rst) // R4
    !flags[AICS_FLG_BIST] && !pci_bist_start |=> !flags[AICS_FLG_BIST])
    else $error("self-test flag set without a start");

  rdone_free_a: assert property (@(posedge clk) disable iff (rst) // R5
    !flags[AICS_FLG_RDONE] && !mst_rd_count_zero |=> !flags[AICS_FLG_RDONE])
    else $error("read count flag set without its event");

  wdone_free_a: assert property (@(posedge clk) disable iff (rst) // R6
    !flags[AICS_FLG_WDONE] && !mst_wr_count_zero |=> !flags[AICS_FLG_WDONE])
    else $error("write count flag set without its event");

  omb_other_a: assert property (@(posedge clk) disable iff (rst) // R13
    !flags[AICS_FLG_OMB] &&
    !pci_omb_rd_byte[state_ff.ctrl[AICS_OMB_SEL_LSB+1:AICS_OMB_BYTE_LSB]]
    |=> !flags[AICS_FLG_OMB])
    else $error("unselected outgoing byte read latched");

  imb_other_a: assert property (@(posedge clk) disable iff (rst) // R16
    !flags[AICS_FLG_IMB] &&
    !pci_imb_wr_byte[state_ff.ctrl[AICS_IMB_SEL_LSB+1:AICS_IMB_BYTE_LSB]]
    |=> !flags[AICS_FLG_IMB])
    else $error("unselected incoming byte write latched");

  // control fields take their lane of a register write
  omb_mbox_a: assert property (@(posedge clk) disable iff (rst) // R12
    wr_hit && addon_be[1] |=>
    state_ff.ctrl[AICS_OMB_SEL_LSB +: 2] == $past(addon_wdata[AICS_OMB_SEL_LSB +: 2]))
    else $error("outgoing mailbox select not written");

  omb_byte_a: assert property (@(posedge clk) disable iff (rst) // R13
    wr_hit && addon_be[1] |=>
    state_ff.ctrl[AICS_OMB_BYTE_LSB +: 2] == $past(addon_wdata[AICS_OMB_BYTE_LSB +: 2]))
    else $error("outgoing byte select not written");

  imb_mbox_a: assert property (@(posedge clk) disable iff (rst) // R15
    wr_hit && addon_be[0] |=>
    state_ff.ctrl[AICS_IMB_SEL_LSB +: 2] == $past(addon_wdata[AICS_IMB_SEL_LSB +: 2]))
    else $error("incoming mailbox select not written");

  imb_byte_a: assert property (@(posedge clk) disable iff (rst) // R16
    wr_hit && addon_be[0] |=>
    state_ff.ctrl[AICS_IMB_BYTE_LSB +: 2] == $past(addon_wdata[AICS_IMB_BYTE_LSB +: 2]))
    else $error("incoming byte select not written");

  rd_enable_a: assert property (@(posedge clk) disable iff (rst) // R9
    wr_hit && addon_be[1] |=>
    state_ff.ctrl[AICS_BIT_EN_RD] == $past(addon_wdata[AICS_BIT_EN_RD]))
    else $error("read count enable not written");

  wr_enable_a: assert property (@(posedge clk) disable iff (rst) // R10
    wr_hit && addon_be[1] |=>
    state_ff.ctrl[AICS_BIT_EN_WR] == $past(addon_wdata[AICS_BIT_EN_WR]))
    else $error("write count enable not written");

  omb_enable_a: assert property (@(posedge clk) disable iff (rst) // R11
    wr_hit && addon_be[1] |=>
    state_ff.ctrl[AICS_BIT_EN_OMB] == $past(addon_wdata[AICS_BIT_EN_OMB]))
    else $error("outgoing mailbox enable not written");

  imb_enable_a: assert property (@(posedge clk) disable iff (rst) // R14
    wr_hit && addon_be[0] |=>
    state_ff.ctrl[AICS_BIT_EN_IMB] == $past(addon_wdata[AICS_BIT_EN_IMB]))
    else $error("incoming mailbox enable not written");

  ctrl_keep_a: assert property (@(posedge clk) disable iff (rst) // R12
    !wr_hit |=> $stable(state_ff.ctrl))
    else $error("control fields changed without a write");

  lane_ctrl_a: assert property (@(posedge clk) disable iff (rst) // R12
    wr_hit && !addon_be[1] |=>
    state_ff.ctrl[AICS_BIT_EN_RD:AICS_OMB_BYTE_LSB] ==
    $past(state_ff.ctrl[AICS_BIT_EN_RD:AICS_OMB_BYTE_LSB]))
    else $error("control byte changed without its lane");

  rsvd_ctrl_a: assert property (@(posedge clk) disable iff (rst) // R17
    (state_ff.ctrl & ~AICS_RW_MASK) == 32'h0000_0000)
    else $error("control register holds a reserved bit");

  rdata_hold_a: assert property (@(posedge clk) disable iff (rst) // R17
    !rd_any |=> $stable(addon_rdata))
    else $error("read data changed without a read");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (rst) // R17
    rd_any && !rd_hit |=> addon_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  irq_set_a: assert property (@(posedge clk) disable iff (rst) // R19
    (flag_set != '0) |=> !addon_irq_n)
    else $error("interrupt not active after a latched event");

endmodule : aics_top

`default_nettype wire

/* File: verification/aics_host_bfm.sv */
// Purpose: add-on bus master model that reaches the interrupt register
// Assumes: one access per call, strobe held for exactly one clock
// Notes: released data is inverted so a stale value never looks valid
`timescale 1ns/1ns
`default_nettype none

module aics_host_bfm (
  input wire logic clk,
  output logic sel,
  output logic [5:2] addr,
  output logic [3:0] be,
  output logic wr,
  output logic rd,
  output logic [31:0] wdata
);
  initial begin
    sel = 1'b0;
    addr = 4'h0;
    be = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 32'h0000_0000;
  end

  task automatic acc(input logic w, input logic [5:2] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(negedge clk);
    sel = 1'b1;
    addr = a;
    be = b;
    wr = w;
    rd = ~w;
    wdata = d;
    @(negedge clk);
    sel = 1'b0;
    addr = ~a;
    be = ~b;
    wr = 1'b0;
    rd = 1'b0;
    wdata = ~d;
  endtask : acc
endmodule : aics_host_bfm

`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for the add-on interrupt register
// Assumes: read data is compared on the falling edge after the read cycle
// Notes: event pulses and bus cycles are both launched on falling edges
`timescale 1ns/1ns
`default_nettype none

module tb;
  import aics_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel, wr, rd, irq_n;
  logic rd_d = 1'b0;
  logic [5:2] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, v, ctrl;
  logic [15:0] imb = 16'h0000;
  logic [15:0] omb = 16'h0000;
  logic [4:0] misc = 5'h00;
  logic [31:0] exp_q[$];
  logic [31:0] rs = 32'h0000_A78C;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  aics_host_bfm bfm_u (.clk(clk), .sel(sel), .addr(addr), .be(be), .wr(wr), .rd(rd),
    .wdata(wdata));

  aics_top dut_u (.clk(clk), .rst(rst), .addon_sel(sel), .addon_addr(addr),
    .addon_be(be), .addon_wr(wr), .addon_rd(rd), .addon_wdata(wdata),
    .addon_rdata(rdata), .pci_imb_wr_byte(imb), .pci_omb_rd_byte(omb),
    .pci_bist_start(misc[2]), .mst_rd_count_zero(misc[0]), .mst_wr_count_zero(misc[1]),
    .pci_master_abort(misc[3]), .pci_target_abort(misc[4]), .addon_irq_n(irq_n));

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [5:2] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bfm_u.acc(1'b0, a, 4'hF, 32'h0000_0000);
  endtask : rd_chk

  task automatic wr_reg(input logic [31:0] d, input logic [3:0] b);
    bfm_u.acc(1'b1, 4'hE, b, d);
  endtask : wr_reg

  // events are one-cycle pulses, as the event sources give them
  task automatic ev(input logic [15:0] im, input logic [15:0] om, input logic [4:0] m);
    @(negedge clk);
    imb = im;
    omb = om;
    misc = m;
    @(negedge clk);
    imb = 16'h0000;
    omb = 16'h0000;
    misc = 5'h00;
  endtask : ev

  always @(posedge clk or posedge rst) begin
    if (rst)
      rd_d <= 1'b0;
    else
      rd_d <= sel & rd;
  end

  // read data stands from the edge after the strobe, so look half a cycle later
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front());
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd_chk(4'hE, AICS_IRQ_RESET);
    chk({31'h0, irq_n}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = xs();
      wr_reg(v, 4'hF);
      rd_chk(4'hE, v & AICS_RW_MASK);
    end
    wr_reg(32'hFFFF_FFFF, 4'hF);
    rd_chk(4'hE, 32'h0000_DF1F);
    bfm_u.acc(1'b1, 4'hD, 4'hF, 32'h0000_0000);
    rd_chk(4'hD, 32'h0000_0000);
    wr_reg(32'h0000_0000, 4'h1);
    rd_chk(4'hE, 32'h0000_DF00);
    $display("test control fields done");
    for (int i = 0; i < 16; i++) begin
      ctrl = 32'h0000_1010 | (i << 8) | i;
      wr_reg(ctrl, 4'hF);
      ev(~(16'h0001 << i), ~(16'h0001 << i), 5'h00);
      rd_chk(4'hE, ctrl);
      ev(16'h0001 << i, 16'h0001 << i, 5'h00);
      rd_chk(4'hE, ctrl | 32'h0083_0000);
      chk({31'h0, irq_n}, 32'h0);
      wr_reg(ctrl | 32'h0003_0000, 4'hF);
      rd_chk(4'hE, ctrl);
      chk({31'h0, irq_n}, 32'h1);
    end
    $display("test mailbox select done");
    wr_reg(32'h0000_0000, 4'hF);
    ev(16'hFFFF, 16'hFFFF, 5'b00011);
    rd_chk(4'hE, 32'h0000_0000);
    wr_reg(32'h0000_C000, 4'hF);
    ev(16'h0000, 16'h0000, 5'b00001);
    rd_chk(4'hE, 32'h0088_C000);
    ev(16'h0000, 16'h0000, 5'b00010);
    rd_chk(4'hE, 32'h008C_C000);
    ev(16'h0000, 16'h0000, 5'b00100);
    rd_chk(4'hE, 32'h009C_C000);
    ev(16'h0000, 16'h0000, 5'b01000);
    rd_chk(4'hE, 32'h00BC_C000);
    wr_reg(32'h0000_C000, 4'hF);
    rd_chk(4'hE, 32'h00BC_C000);
    wr_reg(32'h0020_0000, 4'h4);
    rd_chk(4'hE, 32'h009C_C000);
    wr_reg(32'h003F_FFFF, 4'hB);
    rd_chk(4'hE, 32'h009C_DF1F);
    ev(16'h0000, 16'h0000, 5'b10000);
    rd_chk(4'hE, 32'h00BC_DF1F);
    wr_reg(32'h00FF_0000, 4'h4);
    rd_chk(4'hE, 32'h0000_DF1F);
    chk({31'h0, irq_n}, 32'h1);
    $display("test event sources done");
    // a set landing with its own clear must not be lost
    fork
      ev(16'h0000, 16'h0000, 5'b10000);
      wr_reg(32'h0020_0000, 4'h4);
    join
    rd_chk(4'hE, 32'h00A0_DF1F);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_chk(4'hE, 32'h0000_0000);
    chk({31'h0, irq_n}, 32'h1);
    $display("test set priority and reset done");
    repeat (3) @(negedge clk);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
